/* hdl/sof_regs.vh */
`ifndef SOF_REGS_VH
`define SOF_REGS_VH
// Output mode codes
`define SOF_MODE_DIGITAL_ONLY 2'h0
`define SOF_MODE_WINDOWED 2'h1
`define SOF_MODE_ANALOG_WIN 2'h2
`define SOF_MODE_ANALOG_ONLY 2'h3
// Register offsets
`define SOF_OFS_CTRL 4'h0
`define SOF_OFS_LIMITS_LO 4'h1
`define SOF_OFS_LIMITS_HI 4'h2
`define SOF_OFS_STATUS 4'h3
`define SOF_OFS_RESULT 4'h4
`define SOF_OFS_FAIL 4'h5
`define SOF_OFS_WDG_KICK 4'h6
// Field positions
`define SOF_CTRL_MODE_LSB 0
`define SOF_CTRL_MODE_SET 2
`define SOF_CTRL_STARTUP_DONE 3
// Reset values and diagnostic codes
`define SOF_LIMIT_LO_RST 15'h0000
`define SOF_LIMIT_HI_RST 15'h7FFF
`define SOF_LOW_DIAG_CODE 16'h0000
`define SOF_ERROR_CODE 16'hFFFF
// Timing
`define SOF_WINDOW_MS 500
`define SOF_CLK_MHZ 250
`define SOF_WDG_US 100
`define SOF_OSC_TIMEOUT_CYC 64
`endif

/* hdl/sof_output_failsafe.v */
// Functional notes
// - Offset, drift and third-order nonlinearity corrected upstream.
// - Result is an unsigned 15-bit fraction in [0,1).
// - Result readable over two-wire and one-wire paths.
// - Analog value clipped to programmed lower and upper limits.
// - Output mode chosen from stored configuration or by command.
// - Digital-only: analog off, one-wire readout allowed.
// - Windowed: analog only after startup and window expiry without traffic.
// - Command entry accepted only inside the startup window.
// - Analog-with-window: analog right after startup, entry still accepted.
// - Analog-only: analog after startup, one-wire readout refused.
// - Converter code carries 12.4-bit resolution.
// - Any supervised failure enters diagnostic state.
// - Diagnostic state drives the low diagnostic band.
// - Error present: serial reads return the error code.
// - Watchdog supervises correction cpu execution.
// - Oscillator monitor flags stopped oscillation (no tick within 64 cycles).
// - Memory checks on every access flag failures.
// - Control registers carry parity; mismatch is a failure.
// - Startup error keeps output in low diagnostic band.
// - Command state separate from normal run and diagnostic states.
`timescale 1ns/1ps
`default_nettype none
`include "sof_regs.vh"
module sof_output_failsafe #(
	parameter WINDOW_CYC = `SOF_WINDOW_MS * `SOF_CLK_MHZ * 1000,
	parameter WDG_CYC = `SOF_WDG_US * `SOF_CLK_MHZ
) (
	input wire clock_i,
	input wire reset_n_i,
	input wire [3:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	input wire [14:0] result_i,
	input wire result_valid_i,
	input wire [1:0] cfg_mode_i,
	input wire cfg_ok_i,
	input wire cfg_valid_i,
	input wire mem_access_i,
	input wire mem_check_fail_i,
	input wire osc_tick_i,
	input wire ow_activity_i,
	input wire ow_cmd_entry_i,
	input wire ow_read_req_i,
	output reg [15:0] ow_read_data_o,
	output reg ow_read_ack_o,
	output wire ow_read_refused_o,
	output reg [15:0] output_line_code_o,
	output wire output_line_oe_n_o,
	output wire diagnostic_state_o,
	output wire command_state_o,
	output wire normal_run_state_o
);
	localparam ST_STARTUP = 3'h0;
	localparam ST_WINDOW = 3'h1;
	localparam ST_NORMAL = 3'h2;
	localparam ST_COMMAND = 3'h3;
	localparam ST_DIAG = 3'h4;
	localparam [31:0] WIN_C = WINDOW_CYC;
	localparam [31:0] WDG_C = WDG_CYC;
	localparam [7:0] OSC_C = `SOF_OSC_TIMEOUT_CYC;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [1:0] mode_reg;
	reg mode_par_reg;
	reg [14:0] lim_lo_reg;
	reg lim_lo_par_reg;
	reg [14:0] lim_hi_reg;
	reg lim_hi_par_reg;
	reg [14:0] result_reg;
	reg [31:0] win_cnt_reg;
	reg [31:0] wdg_cnt_reg;
	reg [7:0] osc_cnt_reg;
	reg [4:0] fail_reg;
	reg analog_on_reg;
	reg ow_seen_reg;
	wire par_err;
	wire wdg_err;
	wire osc_err;
	wire any_fail;
	wire [14:0] clipped;
	wire in_window;
	wire wr_ctrl;
	wire wdg_kick;
	wire mem_err;
	wire cfg_err;
	wire cfg_load;
	wire wr_lim_lo;
	wire wr_lim_hi;
	wire ow_read_ok;
	reg [31:0] wdg_cnt_next;
	reg [7:0] osc_cnt_next;
	reg [4:0] fail_next;
	reg [1:0] mode_next;
	reg mode_par_next;
	reg [14:0] lim_lo_next;
	reg lim_lo_par_next;
	reg [14:0] lim_hi_next;
	reg lim_hi_par_next;
	reg [31:0] win_cnt_next;
	reg ow_seen_next;
	reg analog_on_next;
	reg [14:0] result_next;
	reg [15:0] code_next;
	reg [15:0] rdata_next;
	reg [15:0] ow_data_next;
	reg ow_ack_next;

	// ----------------------------------------
	// Failure detection
	// ----------------------------------------
	// Parity check registers
	assign par_err = (^mode_reg ^ mode_par_reg) |
		(^lim_lo_reg ^ lim_lo_par_reg) | (^lim_hi_reg ^ lim_hi_par_reg);
	assign wdg_err = (wdg_cnt_reg >= WDG_C);
	assign osc_err = (osc_cnt_reg >= OSC_C);
	assign mem_err = mem_access_i & mem_check_fail_i;
	assign cfg_err = cfg_valid_i & ~cfg_ok_i & (state_reg == ST_STARTUP);
	assign any_fail = (|fail_reg) | par_err | wdg_err | osc_err | mem_err;
	assign wr_ctrl = wr_i & (addr_i == `SOF_OFS_CTRL);
	assign wdg_kick = wr_i & (addr_i == `SOF_OFS_WDG_KICK);

	always @* begin
		wdg_cnt_next = wdg_cnt_reg;
		osc_cnt_next = osc_cnt_reg;
		if (wdg_kick)
			wdg_cnt_next = 32'h0;
		else if (!wdg_err)
			wdg_cnt_next = wdg_cnt_reg + 32'h1;
		if (osc_tick_i)
			osc_cnt_next = 8'h00;
		else if (!osc_err)
			osc_cnt_next = osc_cnt_reg + 8'h01;
		fail_next = fail_reg |
			{par_err, wdg_err, osc_err, mem_err, cfg_err};
	end

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wdg_cnt_reg <= 32'h0;
			osc_cnt_reg <= 8'h00;
			fail_reg <= 5'h00;
		end else begin
			wdg_cnt_reg <= wdg_cnt_next;
			osc_cnt_reg <= osc_cnt_next;
			fail_reg <= fail_next;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_reg <= `SOF_MODE_ANALOG_ONLY;
			mode_par_reg <= 1'b0;
			lim_lo_reg <= `SOF_LIMIT_LO_RST;
			lim_lo_par_reg <= 1'b0;
			lim_hi_reg <= `SOF_LIMIT_HI_RST;
			lim_hi_par_reg <= 1'b1;
		end else begin
			mode_reg <= mode_next;
			mode_par_reg <= mode_par_next;
			lim_lo_reg <= lim_lo_next;
			lim_lo_par_reg <= lim_lo_par_next;
			lim_hi_reg <= lim_hi_next;
			lim_hi_par_reg <= lim_hi_par_next;
		end
	end

	assign cfg_load = (state_reg == ST_STARTUP) && cfg_valid_i;
	assign wr_lim_lo = wr_i && (addr_i == `SOF_OFS_LIMITS_LO);
	assign wr_lim_hi = wr_i && (addr_i == `SOF_OFS_LIMITS_HI);

	always @* begin
		mode_next = mode_reg;
		mode_par_next = mode_par_reg;
		lim_lo_next = lim_lo_reg;
		lim_lo_par_next = lim_lo_par_reg;
		lim_hi_next = lim_hi_reg;
		lim_hi_par_next = lim_hi_par_reg;
		if (cfg_load) begin
			mode_next = cfg_ok_i ? cfg_mode_i : `SOF_MODE_ANALOG_ONLY;
			mode_par_next = ^mode_next;
		end else if (wr_ctrl & wdata_i[`SOF_CTRL_MODE_SET]) begin
			mode_next = wdata_i[1:0];
			mode_par_next = ^wdata_i[1:0];
		end
		if (wr_lim_lo) begin
			lim_lo_next = wdata_i[14:0];
			lim_lo_par_next = ^wdata_i[14:0];
		end
		if (wr_lim_hi) begin
			lim_hi_next = wdata_i[14:0];
			lim_hi_par_next = ^wdata_i[14:0];
		end
	end

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	// Window open only in window modes
	assign in_window = (state_reg == ST_WINDOW) && (win_cnt_reg < WIN_C);

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_STARTUP: begin
			if (wr_ctrl & wdata_i[`SOF_CTRL_STARTUP_DONE]) begin
				if (mode_reg == `SOF_MODE_WINDOWED ||
					mode_reg == `SOF_MODE_ANALOG_WIN)
					state_next = ST_WINDOW;
				else
					state_next = ST_NORMAL;
			end
		end
		ST_WINDOW: begin
			if (ow_cmd_entry_i)
				state_next = ST_COMMAND;
			else if (!in_window)
				state_next = ST_NORMAL;
		end
		ST_NORMAL: state_next = ST_NORMAL;
		ST_COMMAND: state_next = ST_COMMAND;
		ST_DIAG: state_next = ST_DIAG;
		default: state_next = ST_DIAG;
		endcase
		if (any_fail)
			state_next = ST_DIAG;
	end

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= ST_STARTUP;
			win_cnt_reg <= 32'h0;
			ow_seen_reg <= 1'b0;
			analog_on_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			win_cnt_reg <= win_cnt_next;
			ow_seen_reg <= ow_seen_next;
			analog_on_reg <= analog_on_next;
		end
	end

	always @* begin
		win_cnt_next = win_cnt_reg;
		ow_seen_next = ow_seen_reg;
		if (state_reg == ST_WINDOW)
			win_cnt_next = win_cnt_reg + 32'h1;
		// Traffic in the window blocks a later analog start
		if (state_reg == ST_WINDOW && ow_activity_i)
			ow_seen_next = 1'b1;
		if (state_next == ST_NORMAL &&
			mode_reg == `SOF_MODE_WINDOWED)
			analog_on_next = ~ow_seen_reg;
		else if (state_next == ST_NORMAL || state_next == ST_WINDOW)
			analog_on_next = (mode_reg == `SOF_MODE_ANALOG_WIN) |
				(mode_reg == `SOF_MODE_ANALOG_ONLY);
		else
			analog_on_next = 1'b0;
		if (mode_reg == `SOF_MODE_DIGITAL_ONLY)
			analog_on_next = 1'b0;
	end

	// ----------------------------------------
	// Output path
	// ----------------------------------------
	// Clip to limits
	assign clipped = (result_reg < lim_lo_reg) ? lim_lo_reg :
		(result_reg > lim_hi_reg) ? lim_hi_reg : result_reg;

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result_reg <= 15'h0000;
			output_line_code_o <= `SOF_LOW_DIAG_CODE;
		end else begin
			result_reg <= result_next;
			output_line_code_o <= code_next;
		end
	end

	always @* begin
		result_next = result_reg;
		if (result_valid_i)
			result_next = result_i;
		if (state_reg == ST_DIAG || state_reg == ST_STARTUP)
			code_next = `SOF_LOW_DIAG_CODE;
		else
			code_next = {clipped, 1'b0};
	end

	assign output_line_oe_n_o = ~((analog_on_reg & state_reg != ST_DIAG &
		state_reg != ST_COMMAND) | state_reg == ST_DIAG |
		(state_reg == ST_STARTUP & mode_reg[1]));
	assign diagnostic_state_o = (state_reg == ST_DIAG);
	assign command_state_o = (state_reg == ST_COMMAND);
	assign normal_run_state_o = (state_reg == ST_NORMAL) |
		(state_reg == ST_WINDOW);
	assign ow_read_refused_o = ow_read_req_i &
		(mode_reg == `SOF_MODE_ANALOG_ONLY);

	// ----------------------------------------
	// Readout paths
	// ----------------------------------------
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 16'h0000;
			ow_read_data_o <= 16'h0000;
			ow_read_ack_o <= 1'b0;
		end else begin
			ow_read_ack_o <= ow_ack_next;
			ow_read_data_o <= ow_data_next;
			rdata_o <= rdata_next;
		end
	end

	assign ow_read_ok = ow_read_req_i & ~ow_read_refused_o;

	always @* begin
		ow_ack_next = ow_read_ok;
		ow_data_next = ow_read_data_o;
		if (ow_read_ok)
			ow_data_next = diagnostic_state_o ?
				`SOF_ERROR_CODE : {1'b0, result_reg};
		// Read data stand one cycle only
		rdata_next = 16'h0000;
		if (rd_i) begin
			case (addr_i)
			`SOF_OFS_CTRL: rdata_next = {14'h0000, mode_reg};
			`SOF_OFS_LIMITS_LO: rdata_next = {1'b0, lim_lo_reg};
			`SOF_OFS_LIMITS_HI: rdata_next = {1'b0, lim_hi_reg};
			`SOF_OFS_STATUS: rdata_next = {10'h000, analog_on_reg,
				in_window, 1'b0, state_reg};
			`SOF_OFS_RESULT: rdata_next = diagnostic_state_o ?
				`SOF_ERROR_CODE : {1'b0, result_reg};
			`SOF_OFS_FAIL: rdata_next = {11'h000, fail_reg};
			default: rdata_next = 16'h0000;
			endcase
		end
	end
endmodule
`default_nettype wire

/* bench/sof_output_failsafe_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sof_output_failsafe_properties #(parameter WDG_CYC = 400) (
	input wire clock_i,
	input wire reset_n_i,
	input wire [3:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire [15:0] rdata_o,
	input wire mem_access_i,
	input wire mem_check_fail_i,
	input wire osc_tick_i,
	input wire ow_read_req_i,
	input wire [15:0] ow_read_data_o,
	input wire ow_read_ack_o,
	input wire ow_read_refused_o,
	input wire [15:0] output_line_code_o,
	input wire diagnostic_state_o,
	input wire command_state_o,
	input wire normal_run_state_o
);
// ----------
// Gap counters
// ----------
logic [6:0] gap;
logic [15:0] idle;
always @(posedge clock_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		gap <= 7'h00;
		idle <= 16'h0000;
	end else begin
		gap <= osc_tick_i ? 7'h00 : gap + 7'(gap != 7'h7F);
		idle <= (wr_i && addr_i == 4'h6) ? 16'h0000 : idle + 16'h0001;
	end
end
default clocking @(posedge clock_i); endclocking
default disable iff (!reset_n_i);
a_diag_sticky:
	assert property (diagnostic_state_o |=> diagnostic_state_o) else $error("diag lost");
a_mem_fail:
	assert property (mem_access_i && mem_check_fail_i |=> diagnostic_state_o) else $error("mem");
a_diag_low:
	assert property (diagnostic_state_o |=> output_line_code_o == 16'h0000) else $error("code");
a_err_code:
	assert property (diagnostic_state_o && ow_read_req_i && !ow_read_refused_o
		|=> ow_read_ack_o && ow_read_data_o == 16'hFFFF) else $error("err code");
a_ack_cause:
	assert property (ow_read_ack_o |-> $past(ow_read_req_i)) else $error("ack");
a_refuse_req:
	assert property (ow_read_refused_o |-> ow_read_req_i) else $error("refuse");
a_rd_idle:
	assert property (!rd_i |=> rdata_o == 16'h0000) else $error("rdata");
a_one_state:
	assert property ($onehot0({diagnostic_state_o, command_state_o,
		normal_run_state_o})) else $error("states");
a_osc_lost:
	assert property (gap == 7'd70 |-> diagnostic_state_o) else $error("osc");
a_wdg_lost:
	assert property (idle == WDG_CYC + 40 |-> diagnostic_state_o) else $error("wdg");
endmodule
bind sof_output_failsafe sof_output_failsafe_properties #(.WDG_CYC(WDG_CYC))
	i_sof_props (.clock_i, .reset_n_i, .addr_i, .wr_i, .rd_i, .rdata_o,
	.mem_access_i, .mem_check_fail_i, .osc_tick_i, .ow_read_req_i,
	.ow_read_data_o, .ow_read_ack_o, .ow_read_refused_o,
	.output_line_code_o, .diagnostic_state_o, .command_state_o,
	.normal_run_state_o);
`default_nettype wire

/* bench/sof_ow_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sof_ow_master (
	input wire logic clock_i,
	input wire logic ack_i,
	input wire logic [15:0] data_i,
	input wire logic refused_i,
	output logic activity_o,
	output logic cmd_entry_o,
	output logic read_req_o
);
initial {activity_o, cmd_entry_o, read_req_o} = 3'h0;
task enter_cmd;
	@(posedge clock_i);
	{activity_o, cmd_entry_o} <= 2'h3;
	@(posedge clock_i);
	{activity_o, cmd_entry_o} <= 2'h0;
endtask
task read(output logic [15:0] d, output logic r);
	@(posedge clock_i);
	{activity_o, read_req_o} <= 2'h3;
	#1 r = refused_i;
	@(posedge clock_i);
	{activity_o, read_req_o} <= 2'h0;
	#1 d = ack_i ? data_i : 16'hDEAD;
endtask
endmodule
`default_nettype wire

/* bench/sof_output_failsafe_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("FAIL %0t mismatch", $time); end end
module sof_output_failsafe_tb;
logic clock_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, result_valid_i = 0;
logic cfg_ok_i = 0, cfg_valid_i = 0, mem_access_i = 0, mem_check_fail_i = 0;
logic osc_tick_i = 0, osc_en = 1, r;
logic [3:0] addr_i = 0;
logic [15:0] wdata_i = 0, d;
logic [14:0] result_i = 0;
logic [1:0] cfg_mode_i = 0;
logic [2:0] tc = 0;
wire act, ent, req, ack, refu, oe_n, diag, cmd, norm;
wire [15:0] rdata_o, owd, code;
int error_cnt = 0, total_checks = 0;
always #2 clock_i = ~clock_i;
always @(posedge clock_i) begin
	tc <= tc + 3'h1;
	osc_tick_i <= osc_en && tc == 3'h0;
end
sof_output_failsafe #(.WINDOW_CYC(100), .WDG_CYC(400)) i_sof_output_failsafe (
	.clock_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.result_i, .result_valid_i, .cfg_mode_i, .cfg_ok_i, .cfg_valid_i,
	.mem_access_i, .mem_check_fail_i, .osc_tick_i, .ow_activity_i(act),
	.ow_cmd_entry_i(ent), .ow_read_req_i(req), .ow_read_data_o(owd),
	.ow_read_ack_o(ack), .ow_read_refused_o(refu), .output_line_code_o(code),
	.output_line_oe_n_o(oe_n), .diagnostic_state_o(diag),
	.command_state_o(cmd), .normal_run_state_o(norm));
sof_ow_master i_sof_ow_master (.clock_i, .ack_i(ack), .data_i(owd),
	.refused_i(refu), .activity_o(act), .cmd_entry_o(ent), .read_req_o(req));
task wr(input logic [3:0] a, input logic [15:0] v);
	@(posedge clock_i);
	{addr_i, wdata_i, wr_i} <= {a, v, 1'b1};
	@(posedge clock_i);
	wr_i <= 0;
endtask
task rd(input logic [3:0] a);
	@(posedge clock_i);
	{addr_i, rd_i} <= {a, 1'b1};
	@(posedge clock_i);
	rd_i <= 0;
	#1 d = rdata_o;
endtask
task rst(input logic [1:0] m, input logic ok);
	@(posedge clock_i);
	{reset_n_i, osc_en} <= 2'h1;
	repeat (4) @(posedge clock_i);
	reset_n_i <= 1;
	@(posedge clock_i);
	{cfg_mode_i, cfg_ok_i, cfg_valid_i} <= {m, ok, 1'b1};
	@(posedge clock_i);
	cfg_valid_i <= 0;
endtask
task res(input logic [14:0] v);
	@(posedge clock_i);
	{result_i, result_valid_i} <= {v, 1'b1};
	@(posedge clock_i);
	result_valid_i <= 0;
	repeat (2) @(posedge clock_i);
	#1;
endtask
task t_win;
	rst(2'h2, 1);
	wr(4'h0, 16'h0008);
	repeat (2) @(posedge clock_i);
	#1 `CHK(oe_n, 1'b0)
	i_sof_ow_master.enter_cmd;
	@(posedge clock_i);
	#1 `CHK(cmd, 1'b1)
	rd(4'hF);
	`CHK(d, 16'h0000)
	$display("t_win done");
endtask
task t_late;
	rst(2'h1, 1);
	wr(4'h1, 16'h0100);
	wr(4'h2, 16'h0200);
	wr(4'h0, 16'h0008);
	#1 `CHK(oe_n, 1'b1)
	repeat (110) @(posedge clock_i);
	i_sof_ow_master.enter_cmd;
	@(posedge clock_i);
	#1 `CHK(cmd, 1'b0)
	`CHK(norm, 1'b1)
	`CHK(oe_n, 1'b0)
	res(15'h7FFF);
	`CHK(code, 16'h0400)
	res(15'h0010);
	`CHK(code, 16'h0200)
	$display("t_late done");
endtask
task t_dig;
	rst(2'h0, 1);
	wr(4'h0, 16'h0008);
	res(15'h1234);
	#1 `CHK(oe_n, 1'b1)
	i_sof_ow_master.read(d, r);
	`CHK(r, 1'b0)
	`CHK(d, 16'h1234)
	rd(4'h4);
	`CHK(d, 16'h1234)
	$display("t_dig done");
endtask
task t_ana;
	rst(2'h3, 1);
	wr(4'h0, 16'h0008);
	i_sof_ow_master.read(d, r);
	`CHK(r, 1'b1)
	wr(4'h0, 16'h0004);
	rd(4'h0);
	`CHK(d[1:0], 2'h0)
	rst(2'h2, 0);
	rd(4'h0);
	`CHK(d[1:0], 2'h3)
	$display("t_ana done");
endtask
task t_fail;
	for (int k = 0; k < 4; k++) begin
		rst(2'h0, 1);
		if (k != 3) wr(4'h0, 16'h0008);
		@(posedge clock_i);
		{mem_access_i, mem_check_fail_i} <= {2{k == 0 || k == 3}};
		osc_en <= k != 1;
		@(posedge clock_i);
		{mem_access_i, mem_check_fail_i} <= 2'h0;
		repeat (k == 2 ? 480 : 80) @(posedge clock_i);
		#1 `CHK(diag, 1'b1)
		`CHK(code, 16'h0000)
		rd(4'h4);
		`CHK(d, 16'hFFFF)
	end
	$display("t_fail done");
endtask
task end_of_test;
	$display("checks %0d errors %0d", total_checks, error_cnt);
	if (error_cnt == 0 && total_checks > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
initial begin
	t_win;
	t_late;
	t_dig;
	t_ana;
	t_fail;
	end_of_test;
end
initial begin
	repeat (30000) @(posedge clock_i);
	error_cnt++;
	end_of_test;
end
endmodule
`default_nettype wire
